// [hw/nvmcs_pkg.sv]
package nvmcs_pkg;

    // register byte offsets on the apb window
    localparam logic [7:0] OFF_STAT     = 8'h00;
    localparam logic [7:0] OFF_IDX      = 8'h04;
    localparam logic [7:0] OFF_PARAM    = 8'h08;
    localparam logic [7:0] OFF_PROT     = 8'h0C;
    localparam logic [7:0] OFF_MARGIN   = 8'h10;
    localparam logic [7:0] OFF_INT_STAT = 8'h14;
    localparam logic [7:0] OFF_INT_MASK = 8'h18;

    // nvm_status_register bit positions
    localparam int STAT_DONE   = 7;
    localparam int STAT_AERR   = 5;
    localparam int STAT_PVIOL  = 4;
    localparam int STAT_VERR   = 1;
    localparam int STAT_VUNC   = 0;

    // interrupt status / mask bit positions
    localparam int INT_DONE = 0;
    localparam int INT_ERR  = 1;

    // command codes
    localparam logic [7:0] CMD_USER_MARGIN  = 8'h0D;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
    localparam logic [7:0] CMD_PROG_EE      = 8'h11;
    localparam logic [7:0] CMD_ERASE_EE     = 8'h12;

    // parameter word indices
    localparam logic [2:0] IDX_ADDR_HI   = 3'h0;
    localparam logic [2:0] IDX_ADDR_LO   = 3'h1;
    localparam logic [2:0] IDX_DATA0     = 3'h2;
    localparam logic [2:0] IDX_DATA_LAST = 3'h5;
    localparam int         PARAM_WORDS   = 6;

    // margin level settings
    localparam logic [15:0] MARGIN_NORMAL     = 16'h0000;
    localparam logic [15:0] MARGIN_ERASED     = 16'h0001;
    localparam logic [15:0] MARGIN_PROGRAMMED = 16'h0002;

    // reset and erased values
    localparam logic [15:0] PROT_RST   = 16'hFFFF;
    localparam logic [15:0] ERASED_VAL = 16'hFFFF;

    // memory map defaults
    localparam logic [23:0] EE_BASE_DEF  = 24'h10_0000;
    localparam int          EE_BYTES_DEF = 1024;
    localparam logic [23:0] PF_BASE_DEF  = 24'h80_0000;
    localparam int          PF_BYTES_DEF = 65536;
    localparam int          SECTOR_BYTES = 4;

    // timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int WORD_PROG_NS    = 1000;
    localparam int SECTOR_ERASE_NS = 4000;
    localparam int WORD_PROG_CYC   = (WORD_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SECTOR_ERASE_CYC = (SECTOR_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {EE_NONE, EE_PROG, EE_ERASE} nvmcs_ee_op_e;

    typedef struct packed {
        nvmcs_ee_op_e     op;
        logic [15:0]      offset;
        logic [2:0]       count;
        logic [3:0][15:0] data;
    } nvmcs_ee_req_s;

    typedef struct packed {
        logic        done;
        logic        verr;
        logic        vunc;
        logic [15:0] readback;
    } nvmcs_ee_rsp_s;

    typedef struct packed {
        logic aerr;
        logic pviol;
    } nvmcs_check_s;

endpackage

// [hw/nvmcs_launch_check.sv]
`timescale 1ns/10ps
// launch condition checks on the loaded parameter words
module nvmcs_launch_check
    import nvmcs_pkg::*;
#(
    parameter logic [23:0] EE_BASE  = EE_BASE_DEF,
    parameter int          EE_BYTES = EE_BYTES_DEF,
    parameter logic [23:0] PF_BASE  = PF_BASE_DEF,
    parameter int          PF_BYTES = PF_BYTES_DEF
)(
    input  wire logic [15:0] word0,
    input  wire logic [15:0] word1,
    input  wire logic [15:0] word2,
    input  wire logic [2:0]  index,
    input  wire logic        special_mode,
    input  wire logic [15:0] prot_start,
    output nvmcs_check_s     result
);
    localparam logic [24:0] EE_END = 25'(EE_BASE) + 25'(EE_BYTES);
    localparam logic [24:0] PF_END = 25'(PF_BASE) + 25'(PF_BYTES);

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] base, input logic [24:0] lim);
        in_range = (a >= base) && ({1'b0, a} < lim);
    endfunction

    logic [7:0]  cmd;
    logic [23:0] gaddr;
    logic        in_ee;
    logic        in_pf;
    logic [24:0] off;
    logic [24:0] prog_end;
    logic [24:0] sect_end;

    // field split of the first two parameter words
    assign cmd      = word0[15:8];
    assign gaddr    = {word0[7:0], word1};
    assign in_ee    = in_range(gaddr, EE_BASE, EE_END);
    assign in_pf    = in_range(gaddr, PF_BASE, PF_END);
    assign off      = 25'(gaddr) - 25'(EE_BASE);
    assign prog_end = off + {21'h0, index - 3'h1, 1'b0};
    assign sect_end = (off & ~25'(SECTOR_BYTES - 1)) + 25'(SECTOR_BYTES);

    // error classification per command
    always_comb
    begin
        result = '0;
        case (cmd)
            CMD_USER_MARGIN:
                result.aerr = (index != IDX_DATA0) || !(in_ee || in_pf) || (word2 > MARGIN_PROGRAMMED);
            CMD_FIELD_MARGIN:
                result.aerr = !special_mode || (index != IDX_DATA0) || !(in_ee || in_pf)
                              || (word2 > MARGIN_PROGRAMMED);
            CMD_PROG_EE:
            begin
                result.aerr  = (index < IDX_DATA0) || (index > IDX_DATA_LAST) || !in_ee;
                result.aerr  = result.aerr || gaddr[0] || (prog_end > 25'(EE_BYTES));
                result.pviol = !result.aerr && (prog_end > 25'(prot_start));
            end
            CMD_ERASE_EE:
            begin
                result.aerr  = (index != IDX_ADDR_LO) || !in_ee;
                result.pviol = !result.aerr && (sect_end > 25'(prot_start));
            end
            default:
                result.aerr = 1'b1;
        endcase
    end

endmodule

// [hw/nvmcs_eeprom.sv]
`timescale 1ns/10ps
// eeprom word array with timed program and sector erase
module nvmcs_eeprom
    import nvmcs_pkg::*;
#(
    parameter int EE_BYTES = EE_BYTES_DEF
)(
    input  wire logic    ref_clk,
    input  wire logic    reset_n,
    input  wire logic    start,
    input  nvmcs_ee_req_s req,
    input  wire logic    verify_fault,
    input  wire logic    verify_uncorr,
    output nvmcs_ee_rsp_s rsp
);
    localparam int WORDS = EE_BYTES / 2;
    localparam int AW    = $clog2(WORDS);

    typedef enum logic {EE_IDLE, EE_BUSY} nvmcs_ee_state_e;

    logic [15:0]     mem [WORDS];
    nvmcs_ee_state_e state_reg;
    nvmcs_ee_req_s   req_reg;
    logic [15:0]     timer_reg;
    logic [2:0]      left_reg;
    logic [AW-1:0]   waddr_reg;
    logic [1:0]      slot_reg;

    // sequencing: one timed write per programmed word; erase waits once, then writes the whole sector
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= EE_IDLE;
            req_reg   <= '0;
            timer_reg <= '0;
            left_reg  <= '0;
            waddr_reg <= '0;
            slot_reg  <= '0;
            rsp       <= '0;
        end
        else
        begin
            rsp.done <= 1'b0;
            case (state_reg)
                EE_IDLE:
                    if (start)
                    begin
                        req_reg   <= req;
                        slot_reg  <= '0;
                        rsp.verr  <= 1'b0;
                        rsp.vunc  <= 1'b0;
                        state_reg <= EE_BUSY;
                        if (req.op == EE_ERASE)
                        begin
                            waddr_reg <= AW'(req.offset[15:1]) & ~AW'(SECTOR_BYTES / 2 - 1);
                            left_reg  <= 3'(SECTOR_BYTES / 2);
                            timer_reg <= 16'(SECTOR_ERASE_CYC);
                        end
                        else
                        begin
                            waddr_reg <= AW'(req.offset[15:1]);
                            left_reg  <= req.count;
                            timer_reg <= 16'(WORD_PROG_CYC);
                        end
                    end
                EE_BUSY:
                begin
                    rsp.verr <= rsp.verr | verify_fault;
                    rsp.vunc <= rsp.vunc | verify_uncorr;
                    if (timer_reg != 16'h0000)
                        timer_reg <= timer_reg - 16'h0001;
                    else
                    begin
                        mem[waddr_reg] <= (req_reg.op == EE_ERASE) ? ERASED_VAL : req_reg.data[slot_reg];
                        // first word read back from the array; a lone word is not stored yet
                        if ((left_reg == 3'h1) && (slot_reg == 2'h0))
                            rsp.readback <= (req_reg.op == EE_ERASE) ? ERASED_VAL : req_reg.data[0];
                        else if (left_reg == 3'h1)
                            rsp.readback <= mem[waddr_reg - AW'(slot_reg)];
                        waddr_reg <= waddr_reg + AW'(1);
                        slot_reg  <= slot_reg + 2'h1;
                        left_reg  <= left_reg - 3'h1;
                        if (req_reg.op == EE_PROG)
                            timer_reg <= 16'(WORD_PROG_CYC);
                        if (left_reg == 3'h1)
                        begin
                            rsp.done  <= 1'b1;
                            state_reg <= EE_IDLE;
                        end
                    end
                end
                default:
                    state_reg <= EE_IDLE;
            endcase
        end
    end

endmodule

// [hw/nvmcs_top.sv]
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module nvmcs_top
    import nvmcs_pkg::*;
#(
    parameter logic [23:0] EE_BASE  = EE_BASE_DEF,
    parameter int          EE_BYTES = EE_BYTES_DEF,
    parameter logic [23:0] PF_BASE  = PF_BASE_DEF,
    parameter int          PF_BYTES = PF_BYTES_DEF
)(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        special_mode_pin,
    input  wire logic        verify_fault,
    input  wire logic        verify_uncorr,
    output logic [1:0]       read_margin_ee,
    output logic [1:0]       read_margin_pf
);
    typedef enum logic [1:0] {S_IDLE, S_CHECK, S_WAIT} nvmcs_state_e;

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
        merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFF_STAT) || (a == OFF_IDX) || (a == OFF_PARAM) || (a == OFF_PROT)
                 || (a == OFF_MARGIN) || (a == OFF_INT_STAT) || (a == OFF_INT_MASK);
    endfunction

    nvmcs_state_e  state_reg;
    logic [15:0]   param_reg [PARAM_WORDS];
    logic [2:0]    idx_reg;
    logic          done_reg;
    logic          aerr_reg;
    logic          pviol_reg;
    logic          verr_reg;
    logic          vunc_reg;
    logic [15:0]   prot_reg;
    logic [1:0]    user_ee_reg;
    logic [1:0]    user_pf_reg;
    logic [1:0]    field_ee_reg;
    logic [1:0]    field_pf_reg;
    logic [1:0]    int_stat_reg;
    logic [1:0]    int_mask_reg;
    logic          mode_s1_reg;
    logic          mode_s2_reg;
    logic          mode_s3_reg;
    logic          special_reg;
    nvmcs_check_s  chk;
    nvmcs_ee_req_s ee_req;
    nvmcs_ee_rsp_s ee_rsp;
    logic          ee_start;
    logic          wr_acc;
    logic          rd_setup;
    logic          launch;
    logic          cmd_done;
    logic          cmd_err;
    logic [31:0]   rd_mux;
    logic [7:0]    cmd;
    logic          target_ee;
    logic [1:0]    margin_sel;

    // apb strobes
    assign wr_acc   = psel && penable && pwrite && mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped(paddr);

    // launch: write one to the flag while idle; the write itself clears it
    assign launch = wr_acc && (paddr == OFF_STAT) && pwdata[STAT_DONE] && done_reg;

    assign cmd        = param_reg[0][15:8];
    assign target_ee  = ({param_reg[0][7:0], param_reg[1]} >= EE_BASE)
                        && ({1'b0, param_reg[0][7:0], param_reg[1]} < 25'(EE_BASE) + 25'(EE_BYTES));
    assign margin_sel = param_reg[2][1:0];

    // pin synchroniser for the operating mode level
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_s1_reg <= 1'b0;
            mode_s2_reg <= 1'b0;
            mode_s3_reg <= 1'b0;
            special_reg <= 1'b0;
        end
        else
        begin
            mode_s1_reg <= special_mode_pin;
            mode_s2_reg <= mode_s1_reg;
            mode_s3_reg <= mode_s2_reg;
            if (mode_s2_reg == mode_s3_reg)
                special_reg <= mode_s3_reg;
        end
    end

    nvmcs_launch_check #(
        .EE_BASE  (EE_BASE),
        .EE_BYTES (EE_BYTES),
        .PF_BASE  (PF_BASE),
        .PF_BYTES (PF_BYTES)
    ) u_check (
        .word0        (param_reg[0]),
        .word1        (param_reg[1]),
        .word2        (param_reg[2]),
        .index        (idx_reg),
        .special_mode (special_reg),
        .prot_start   (prot_reg),
        .result       (chk)
    );

    // program or erase request built from the locked parameter words
    always_comb
    begin
        ee_req        = '0;
        ee_req.op     = (cmd == CMD_ERASE_EE) ? EE_ERASE : EE_PROG;
        ee_req.offset = 16'({param_reg[0][7:0], param_reg[1]} - EE_BASE);
        ee_req.count  = idx_reg - 3'h1;
        ee_req.data   = {param_reg[5], param_reg[4], param_reg[3], param_reg[2]};
    end

    assign ee_start = (state_reg == S_CHECK) && !chk.aerr && !chk.pviol
                      && ((cmd == CMD_PROG_EE) || (cmd == CMD_ERASE_EE));

    nvmcs_eeprom #(
        .EE_BYTES (EE_BYTES)
    ) u_eeprom (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .start         (ee_start),
        .req           (ee_req),
        .verify_fault  (verify_fault),
        .verify_uncorr (verify_uncorr),
        .rsp           (ee_rsp)
    );

    // command sequencer and completion flag
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= S_IDLE;
            done_reg  <= 1'b1;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                    if (launch)
                    begin
                        done_reg  <= 1'b0;
                        state_reg <= S_CHECK;
                    end
                S_CHECK:
                    if (ee_start)
                        state_reg <= S_WAIT;
                    else
                    begin
                        done_reg  <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                S_WAIT:
                    if (ee_rsp.done)
                    begin
                        done_reg  <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    assign cmd_done = ((state_reg == S_CHECK) && !ee_start) || ((state_reg == S_WAIT) && ee_rsp.done);
    assign cmd_err  = (state_reg == S_CHECK) && (chk.aerr || chk.pviol);

    // error and verify flags; hardware set of the error flags wins over software clear, verify flags have no software clear
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aerr_reg   <= 1'b0;
            pviol_reg  <= 1'b0;
            verr_reg   <= 1'b0;
            vunc_reg   <= 1'b0;
        end
        else
        begin
            if (wr_acc && (paddr == OFF_STAT) && pstrb[0])
            begin
                if (pwdata[STAT_AERR])
                    aerr_reg <= 1'b0;
                if (pwdata[STAT_PVIOL])
                    pviol_reg <= 1'b0;
            end
            if (state_reg == S_CHECK)
            begin
                if (chk.aerr)
                    aerr_reg <= 1'b1;
                if (chk.pviol)
                    pviol_reg <= 1'b1;
                if (ee_start)
                begin
                    verr_reg <= 1'b0;
                    vunc_reg <= 1'b0;
                end
            end
            if ((state_reg == S_WAIT) && ee_rsp.done)
            begin
                verr_reg <= ee_rsp.verr;
                vunc_reg <= ee_rsp.vunc;
            end
        end
    end

    // parameter words and index: software writes only while idle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idx_reg <= '0;
            for (int i = 0; i < PARAM_WORDS; i++)
                param_reg[i] <= '0;
        end
        else
        begin
            if (wr_acc && done_reg && (paddr == OFF_IDX) && pstrb[0])
                idx_reg <= pwdata[2:0];
            if (wr_acc && done_reg && (paddr == OFF_PARAM) && (idx_reg <= IDX_DATA_LAST))
                param_reg[idx_reg] <= merge16(param_reg[idx_reg], pwdata, pstrb);
            if ((state_reg == S_WAIT) && ee_rsp.done)
                param_reg[IDX_DATA0] <= ee_rsp.readback;
        end
    end

    // protection boundary and margin levels
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prot_reg     <= PROT_RST;
            user_ee_reg  <= MARGIN_NORMAL[1:0];
            user_pf_reg  <= MARGIN_NORMAL[1:0];
            field_ee_reg <= MARGIN_NORMAL[1:0];
            field_pf_reg <= MARGIN_NORMAL[1:0];
        end
        else
        begin
            if (wr_acc && done_reg && (paddr == OFF_PROT))
                prot_reg <= merge16(prot_reg, pwdata, pstrb);
            if ((state_reg == S_CHECK) && !chk.aerr)
            begin
                if (cmd == CMD_USER_MARGIN)
                begin
                    if (target_ee)
                        user_ee_reg <= margin_sel;
                    else
                        user_pf_reg <= margin_sel;
                end
                if (cmd == CMD_FIELD_MARGIN)
                begin
                    if (target_ee)
                        field_ee_reg <= margin_sel;
                    else
                        field_pf_reg <= margin_sel;
                end
            end
        end
    end

    // read level seen by the arrays; a field setting other than normal overrides the user one
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_margin_ee <= MARGIN_NORMAL[1:0];
            read_margin_pf <= MARGIN_NORMAL[1:0];
        end
        else
        begin
            read_margin_ee <= (field_ee_reg != MARGIN_NORMAL[1:0]) ? field_ee_reg : user_ee_reg;
            read_margin_pf <= (field_pf_reg != MARGIN_NORMAL[1:0]) ? field_pf_reg : user_pf_reg;
        end
    end

    // interrupt status (write one to clear, set wins) and mask
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            int_stat_reg <= '0;
            int_mask_reg <= '0;
        end
        else
        begin
            if (wr_acc && (paddr == OFF_INT_MASK) && pstrb[0])
                int_mask_reg <= pwdata[1:0];
            if (wr_acc && (paddr == OFF_INT_STAT) && pstrb[0])
                int_stat_reg <= int_stat_reg & ~pwdata[1:0];
            if (cmd_done)
                int_stat_reg[INT_DONE] <= 1'b1;
            if (cmd_err)
                int_stat_reg[INT_ERR] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= |(int_stat_reg & int_mask_reg);
    end

    // read mux; parameter results hidden until the command completes
    always_comb
    begin
        rd_mux = '0;
        case (paddr)
            OFF_STAT:
            begin
                rd_mux[STAT_DONE]   = done_reg;
                rd_mux[STAT_AERR]   = aerr_reg;
                rd_mux[STAT_PVIOL]  = pviol_reg;
                rd_mux[STAT_VERR]   = verr_reg;
                rd_mux[STAT_VUNC]   = vunc_reg;
            end
            OFF_IDX:      rd_mux[2:0] = idx_reg;
            OFF_PARAM:    rd_mux[15:0] = (done_reg && (idx_reg <= IDX_DATA_LAST))
                                         ? param_reg[idx_reg] : 16'h0000;
            OFF_PROT:     rd_mux[15:0] = prot_reg;
            OFF_MARGIN:   rd_mux[7:0] = {field_ee_reg, field_pf_reg, user_ee_reg, user_pf_reg};
            OFF_INT_STAT: rd_mux[1:0] = int_stat_reg;
            OFF_INT_MASK: rd_mux[1:0] = int_mask_reg;
            default:      rd_mux = '0;
        endcase
    end

    // read data registered in the setup phase
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            prdata <= '0;
        else if (rd_setup)
            prdata <= rd_mux;
    end

endmodule

// [test/nvmcs_props.sv]
`timescale 1ns/10ps
// port checks
module nvmcs_props
    import nvmcs_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  read_margin_ee,
    input wire logic [1:0]  read_margin_pf
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire rd = psel & penable & !pwrite;
    // bus answer and register shape
    property p_rdy; psel && penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_map; psel && penable && paddr > OFF_INT_MASK |-> pslverr; endproperty
    a_map: assert property (p_map) else $error("slverr");
    property p_sta; rd && paddr == OFF_STAT |-> prdata[31:8] == 24'h0 && !prdata[6]; endproperty
    a_sta: assert property (p_sta) else $error("stat");
    property p_idx; rd && paddr == OFF_IDX |-> prdata[31:3] == 29'h0; endproperty
    a_idx: assert property (p_idx) else $error("index");
    property p_par; rd && paddr == OFF_PARAM |-> !pslverr && prdata[31:16] == 16'h0; endproperty
    a_par: assert property (p_par) else $error("param");
    // margins legal, moved only after bus traffic
    property p_mee; read_margin_ee != 2'h3; endproperty
    a_mee: assert property (p_mee) else $error("ee margin");
    property p_mpf; read_margin_pf != 2'h3; endproperty
    a_mpf: assert property (p_mpf) else $error("pf margin");
    property p_chg; $changed({read_margin_ee, read_margin_pf}) |-> $past(psel, 2) || $past(psel, 3); endproperty
    a_chg: assert property (p_chg) else $error("margin moved");
endmodule

// [test/nvm_command_sequencer_tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin n_fail++; $display("Error %0t %h %h", $time, g, x); end end
module nvm_command_sequencer_tb_top
    import nvmcs_pkg::*;
;
    logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, e;
    logic        special_mode_pin, verify_fault, verify_uncorr;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  read_margin_ee, read_margin_pf;
    int          n_fail = 0, tests_run = 0;
    // device under test
    nvmcs_top dut (.*);
    // bus clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // verdict and end of run
    task conclude;
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer, waits for ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // clear flags, load words 0..2, set index, launch
    task automatic cmd(input logic [15:0] w0, w1, w2, input logic [2:0] ix);
        xfer(1'b1, OFF_STAT, 32'h30);
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, OFF_IDX, 32'(i));
            xfer(1'b1, OFF_PARAM, {16'h0, i == 0 ? w0 : i == 1 ? w1 : w2});
        end
        xfer(1'b1, OFF_IDX, {29'h0, ix});
        xfer(1'b1, OFF_STAT, 32'h80);
    endtask
    // poll until the complete flag returns
    task automatic waitc;
        do xfer(1'b0, OFF_STAT, 32'h0); while (r[STAT_DONE] !== 1'b1);
    endtask
    // program, locked writes, result word, interrupt
    task automatic t_prog;
        xfer(1'b0, OFF_STAT, 32'h0);
        `CHK(r, 32'h80)
        xfer(1'b1, OFF_INT_MASK, 32'h1);
        cmd(16'h1110, 16'h0004, 16'hA5A5, 3'h2);
        xfer(1'b1, OFF_IDX, 32'h5);
        xfer(1'b0, OFF_PARAM, 32'h0);
        `CHK(r, 32'h0)
        waitc;
        xfer(1'b0, OFF_IDX, 32'h0);
        `CHK({r, irq}, 33'h5)
        xfer(1'b0, OFF_PARAM, 32'h0);
        `CHK(r, 32'hA5A5)
        xfer(1'b1, OFF_INT_STAT, 32'h3);
        xfer(1'b0, OFF_INT_STAT, 32'h0);
        `CHK({r, irq}, 33'h0)
    endtask
    // words, index, pins, status, margins per launch
    task automatic t_tab;
        logic [67:0] tc [14] = '{68'h111000000000_10A00, 68'h111000010000_20A00,
            68'h111003FE0000_30A00, 68'h111000000000_60A00, 68'h111000000001_28900,
            68'h111000000001_26830, 68'h0D1000000002_20838, 68'h0D1000000003_20A38,
            68'h0D1000000001_10A38, 68'h0E1000000001_20A38, 68'h0D1000000000_20830,
            68'h0D8000000001_20831, 68'h0E1000000001_21835, 68'h121000020000_10805};
        for (int i = 0; i < 14; i++)
        begin
            {verify_fault, verify_uncorr, special_mode_pin} <= tc[i][14:12];
            xfer(1'b1, OFF_PROT, {16'h0, {16{!tc[i][15]}}});
            cmd(tc[i][67:52], tc[i][51:36], tc[i][35:20], tc[i][18:16]);
            waitc;
            `CHK(r[7:0], tc[i][11:4])
            `CHK({read_margin_ee, read_margin_pf}, tc[i][3:0])
        end
        xfer(1'b1, OFF_IDX, 32'h2);
        xfer(1'b0, OFF_PARAM, 32'h0);
        `CHK(r, 32'hFFFF)
        xfer(1'b0, 8'h40, 32'h0);
        `CHK({e, r}, 33'h100000000)
    endtask
    // reset, scenarios, verdict
    initial
    begin
        {reset_n, psel, penable, pwrite, special_mode_pin, verify_fault, verify_uncorr} = 7'h0;
        {paddr, pwdata, pstrb} = {40'h0, 4'hF};
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_prog;
        t_tab;
        conclude;
    end
    // hang guard
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        conclude;
    end
endmodule
bind nvmcs_top nvmcs_props u_props (.*);
